// >>> logic/breaker_pkg.sv
// Function
// - state code: none=0 intermediate, open only=1, closed only=2, both=3 bad.
// - state-change events come from the same code shown to the display.
// - a command issues only while all qualifying conditions hold, else blocked.
// - local commands need local permission, remote commands need remote permission.
// - open needs open_permit, close needs close_permit, at the moment of issue.
// - close also needs sync_check_ok; open ignores it.
// - local and remote command operation are enabled independently.
// - operation_block inhibits all command operation while asserted.
// - operation_pulse lasts 150 ms per completed operation; counter counts each.
// - unintended_change flags a status change with no remote command or external switch.
// - open and close command pulses last the configured pulse duration, one ms if it is zero.
package breaker_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_W = 16;
  localparam logic [15:0] OP_PULSE_MS = 16'h0096;
  localparam logic [15:0] PULSE_MS_RST = 16'h03e8;

  // ==========================================================
  // register map
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_PULSE = 8'h0c;
  localparam logic [7:0] ADR_COUNT = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;

  localparam int unsigned CTRL_LOCAL_EN = 0;
  localparam int unsigned CTRL_REMOTE_EN = 1;
  localparam int unsigned CTRL_SOFT_CLR = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;

  localparam int unsigned CMD_OPEN = 0;
  localparam int unsigned CMD_CLOSE = 1;
  localparam int unsigned CMD_REMOTE = 2;

  localparam int unsigned IRQ_STATE = 0;
  localparam int unsigned IRQ_BLOCKED = 1;
  localparam int unsigned IRQ_UNINT = 2;
  localparam int unsigned IRQ_OPER = 3;
  localparam int unsigned IRQ_ISSUED = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // ==========================================================
  // synchronised pin inputs
  localparam int unsigned IN_CLOSED = 0;
  localparam int unsigned IN_OPEN = 1;
  localparam int unsigned IN_LOCAL = 2;
  localparam int unsigned IN_REMOTE = 3;
  localparam int unsigned IN_OPEN_OK = 4;
  localparam int unsigned IN_CLOSE_OK = 5;
  localparam int unsigned IN_SYNC = 6;
  localparam int unsigned IN_BLOCK = 7;
  localparam int unsigned IN_EXT = 8;
  localparam int unsigned IN_W = 9;

  typedef enum logic [1:0] {
    STATE_MID = 2'b00,
    STATE_OFF = 2'b01,
    STATE_ON = 2'b10,
    STATE_BAD = 2'b11
  } breaker_state_t;

endpackage

// >>> logic/pulse_timer.sv
`timescale 1ns/100ps
module pulse_timer #(
  parameter int unsigned TICK = breaker_pkg::TICK_CYCLES,
  parameter int unsigned LEN_W = breaker_pkg::MS_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic start,
  input wire logic [LEN_W-1:0] length_ms,
  output logic active
);
  localparam int unsigned PRE_W = $clog2(TICK + 1);

  logic [PRE_W-1:0] prescale;
  logic [LEN_W-1:0] remaining;
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] len_eff;
  logic [31:0] cyc_cnt;
  logic tick;

  // zero length would wrap and run 65536 ms; run it as one ms
  assign len_eff = (length_ms == '0) ? LEN_W'(1) : length_ms;
  // private prescaler restarts with the pulse, so the length is exact
  assign tick = (prescale == PRE_W'(TICK - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      prescale <= '0;
      remaining <= '0;
      len_q <= '0;
    end else if (clear) begin
      active <= 1'b0;
      prescale <= '0;
      remaining <= '0;
    end else if (start) begin
      active <= 1'b1;
      prescale <= '0;
      remaining <= len_eff;
      len_q <= len_eff;
    end else if (active) begin
      if (tick) begin
        prescale <= '0;
        remaining <= remaining - 1'b1;
        if (remaining == LEN_W'(1)) begin
          active <= 1'b0;
        end
      end else begin
        prescale <= prescale + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt <= 32'h0;
    end else if (start) begin
      cyc_cnt <= 32'h0;
    end else if (active) begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  pulse_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(active) && !$past(clear) && !$past(start) |-> cyc_cnt == 32'(len_q) * TICK)
    else $error("pulse length differs from programmed duration");

endmodule // pulse_timer

// >>> logic/breaker_state_and_command_gate.sv
`timescale 1ns/100ps
module breaker_state_and_command_gate #(
  parameter int unsigned TICK_CYCLES = breaker_pkg::TICK_CYCLES,
  parameter int unsigned CNT_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [breaker_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic closed_status_in,
  input wire logic open_status_in,
  input wire logic local_permit,
  input wire logic remote_permit,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic sync_check_ok,
  input wire logic operation_block,
  input wire logic external_switch_seen,
  output logic open_cmd_pulse,
  output logic close_cmd_pulse,
  output logic operation_pulse,
  output logic unintended_change,
  output breaker_pkg::breaker_state_t breaker_state_code,
  output logic state_event,
  output logic irq
);
  import breaker_pkg::*;

  // ==========================================================
  // declarations
  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  breaker_state_t prev_code;
  logic code_change;
  logic op_start;
  logic [1:0] ctrl;
  logic [MS_W-1:0] pulse_ms;
  logic [CNT_W-1:0] op_count;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic blocked_last;
  logic remote_pending;
  logic ext_pending;
  logic wb_req;
  logic wr_en;
  logic cmd_wr;
  logic soft_clr;
  logic cmd_abort;
  logic remote_sel;
  logic src_ok;
  logic busy;
  logic open_go;
  logic close_go;
  logic blocked_evt;
  logic [31:0] rd_data;

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction

  // ==========================================================
  // pin synchronisers
  assign pins = {external_switch_seen, operation_block, sync_check_ok, close_permit,
                 open_permit, remote_permit, local_permit, open_status_in, closed_status_in};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // ==========================================================
  // state code and events
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      breaker_state_code <= STATE_MID;
      prev_code <= STATE_MID;
    end else begin
      breaker_state_code <= breaker_state_t'({sync2[IN_CLOSED], sync2[IN_OPEN]});
      prev_code <= breaker_state_code;
    end
  end

  assign code_change = (breaker_state_code != prev_code);
  // only a settled off or on counts as a completed operation
  assign op_start = code_change &&
                    (breaker_state_code == STATE_OFF || breaker_state_code == STATE_ON);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_event <= 1'b0;
    end else begin
      state_event <= code_change;
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the request, then drop
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_en = wb_req && wb_we_i && wb_ack_o;
  assign cmd_wr = wr_en && reg_hit(wb_adr_i, ADR_CMD) && wb_sel_i[0];
  assign soft_clr = wr_en && reg_hit(wb_adr_i, ADR_CTRL) && wb_sel_i[0] &&
                    wb_dat_i[CTRL_SOFT_CLR];
  assign cmd_abort = soft_clr || sync2[IN_BLOCK];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      ADR_CTRL: rd_data = {30'h0, ctrl};
      ADR_STATUS: rd_data = {25'h0, blocked_last, unintended_change, operation_pulse,
                             close_cmd_pulse, open_cmd_pulse, breaker_state_code};
      ADR_PULSE: rd_data = {16'h0, pulse_ms};
      ADR_COUNT: rd_data = 32'(op_count);
      ADR_IRQ_STAT: rd_data = {27'h0, irq_stat};
      ADR_IRQ_MASK: rd_data = {27'h0, irq_mask};
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      pulse_ms <= PULSE_MS_RST;
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_en) begin
      if (reg_hit(wb_adr_i, ADR_CTRL) && wb_sel_i[0]) begin
        ctrl <= wb_dat_i[1:0];
      end
      if (reg_hit(wb_adr_i, ADR_PULSE) && wb_sel_i[0]) begin
        pulse_ms[7:0] <= wb_dat_i[7:0];
      end
      if (reg_hit(wb_adr_i, ADR_PULSE) && wb_sel_i[1]) begin
        pulse_ms[15:8] <= wb_dat_i[15:8];
      end
      if (reg_hit(wb_adr_i, ADR_IRQ_MASK) && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // command gate
  assign remote_sel = wb_dat_i[CMD_REMOTE];
  assign src_ok = remote_sel ? (ctrl[CTRL_REMOTE_EN] && sync2[IN_REMOTE])
                             : (ctrl[CTRL_LOCAL_EN] && sync2[IN_LOCAL]);
  // a new command is refused and flagged blocked while a pulse runs, rather than cutting it
  assign busy = open_cmd_pulse || close_cmd_pulse;
  assign open_go = cmd_wr && wb_dat_i[CMD_OPEN] && !wb_dat_i[CMD_CLOSE] && src_ok &&
                   sync2[IN_OPEN_OK] && !sync2[IN_BLOCK] && !busy && !soft_clr;
  assign close_go = cmd_wr && wb_dat_i[CMD_CLOSE] && !wb_dat_i[CMD_OPEN] && src_ok &&
                    sync2[IN_CLOSE_OK] && sync2[IN_SYNC] &&
                    !sync2[IN_BLOCK] && !busy && !soft_clr;
  assign blocked_evt = cmd_wr && (wb_dat_i[CMD_OPEN] || wb_dat_i[CMD_CLOSE]) &&
                       !open_go && !close_go;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocked_last <= 1'b0;
    end else if (open_go || close_go) begin
      blocked_last <= 1'b0;
    end else if (blocked_evt) begin
      blocked_last <= 1'b1;
    end
  end

  pulse_timer #(
    .TICK(TICK_CYCLES),
    .LEN_W(MS_W)
  ) open_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(cmd_abort),
    .start(open_go),
    .length_ms(pulse_ms),
    .active(open_cmd_pulse)
  );

  pulse_timer #(
    .TICK(TICK_CYCLES),
    .LEN_W(MS_W)
  ) close_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(cmd_abort),
    .start(close_go),
    .length_ms(pulse_ms),
    .active(close_cmd_pulse)
  );

  // ==========================================================
  // operation pulse, counter, unintended change
  pulse_timer #(
    .TICK(TICK_CYCLES),
    .LEN_W(MS_W)
  ) oper_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(soft_clr),
    .start(op_start),
    .length_ms(OP_PULSE_MS),
    .active(operation_pulse)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_count <= '0;
    end else if (soft_clr) begin
      op_count <= '0;
    end else if (op_start) begin
      op_count <= op_count + 1'b1;
    end
  end

  // a remote command issued in the same cycle as a change stays pending for the next one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_pending <= 1'b0;
      ext_pending <= 1'b0;
    end else begin
      remote_pending <= ((open_go || close_go) && remote_sel) ||
                        (remote_pending && !op_start && !soft_clr);
      ext_pending <= sync2[IN_EXT] || (ext_pending && !op_start && !soft_clr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unintended_change <= 1'b0;
    end else if (soft_clr) begin
      unintended_change <= 1'b0;
    end else if (op_start) begin
      unintended_change <= !(remote_pending || ext_pending || sync2[IN_EXT]);
    end
  end

  // ==========================================================
  // interrupts: set wins over a same-cycle write-one clear
  assign irq_event[IRQ_STATE] = code_change;
  assign irq_event[IRQ_BLOCKED] = blocked_evt;
  assign irq_event[IRQ_UNINT] = op_start && !(remote_pending || ext_pending || sync2[IN_EXT]);
  assign irq_event[IRQ_OPER] = op_start;
  assign irq_event[IRQ_ISSUED] = open_go || close_go;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else if (wr_en && reg_hit(wb_adr_i, ADR_IRQ_STAT) && wb_sel_i[0]) begin
      irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  state_code_a: assert property (
    !$past(!rst_n, 3) |-> breaker_state_code ==
      breaker_state_t'($past({closed_status_in, open_status_in}, 3)))
    else $error("state code does not follow position inputs");

  state_event_a: assert property (
    $changed(breaker_state_code) |=> state_event)
    else $error("state change without event");

  block_inhibit_a: assert property (
    cmd_wr && sync2[IN_BLOCK] |=> !open_cmd_pulse && !close_cmd_pulse)
    else $error("command pulse while blocked");

  source_perm_a: assert property (
    cmd_wr && !src_ok |=> !$rose(open_cmd_pulse) && !$rose(close_cmd_pulse))
    else $error("command issued without source permission");

  open_permit_a: assert property (
    $rose(open_cmd_pulse) |-> $past(sync2[IN_OPEN_OK]) && $past(cmd_wr))
    else $error("open issued without open permit");

  close_sync_a: assert property (
    $rose(close_cmd_pulse) |-> $past(sync2[IN_CLOSE_OK]) && $past(sync2[IN_SYNC]))
    else $error("close issued without permit or synchro-check");

  local_alone_a: assert property (
    cmd_wr && !remote_sel && ctrl[CTRL_LOCAL_EN] && sync2[IN_LOCAL] && !busy &&
    wb_dat_i[CMD_OPEN] && !wb_dat_i[CMD_CLOSE] && sync2[IN_OPEN_OK] &&
    !sync2[IN_BLOCK] && !soft_clr |=> open_cmd_pulse)
    else $error("enabled local open command not issued");

  block_drop_a: assert property (
    sync2[IN_BLOCK] |=> !open_cmd_pulse && !close_cmd_pulse)
    else $error("command pulse survives block");

  op_count_a: assert property (
    $rose(operation_pulse) |-> op_count == $past(op_count) + 1'b1)
    else $error("operation counter not advanced with pulse");

  unintended_a: assert property (
    $rose(unintended_change) |-> $past(op_start) && !$past(remote_pending) &&
      !$past(ext_pending) && !$past(sync2[IN_EXT]))
    else $error("unintended change flagged with a known cause");

  soft_clear_a: assert property (
    soft_clr |=> op_count == '0 && !open_cmd_pulse && !close_cmd_pulse &&
      !operation_pulse && !unintended_change)
    else $error("synchronous clear left state behind");

endmodule // breaker_state_and_command_gate

// >>> tb/breaker_model.sv
`timescale 1ns/100ps
// ==========================================================
// breaker mechanism: contacts pass through mid position on travel
module breaker_model #(
  parameter int TRAVEL = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic man_move,
  input wire logic bad,
  output logic closed_status_in,
  output logic open_status_in
);
  logic closed;
  logic moving;
  logic oc_d;
  logic cc_d;
  int cnt;
  // edge detect: a coil held on must not restart travel
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      closed <= 1'b0;
      moving <= 1'b0;
      oc_d <= 1'b0;
      cc_d <= 1'b0;
      cnt <= 0;
    end else begin
      oc_d <= open_cmd;
      cc_d <= close_cmd;
      if (moving) begin
        cnt <= cnt + 1;
        if (cnt == TRAVEL) begin
          closed <= !closed;
          moving <= 1'b0;
        end
      end else if (man_move || (open_cmd && !oc_d && closed) ||
                   (close_cmd && !cc_d && !closed)) begin
        moving <= 1'b1;
        cnt <= 0;
      end
    end
  end
  // welded or faulty contacts show both positions at once
  assign closed_status_in = bad | (closed & !moving);
  assign open_status_in = bad | (!closed & !moving);
endmodule // breaker_model

// >>> tb/tb_breaker_state_and_command_gate.sv
`timescale 1ns/100ps
// ==========================================================
// signals
module tb_breaker_state_and_command_gate;
  import breaker_pkg::*;
  localparam int TK = 4;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
  logic wb_ack_o, closed_status_in, open_status_in, open_cmd_pulse, close_cmd_pulse;
  logic operation_pulse, unintended_change, state_event, irq;
  breaker_state_t breaker_state_code, prev;
  logic local_permit = 0, remote_permit = 0, open_permit = 0, close_permit = 0;
  logic sync_check_ok = 0, operation_block = 0, external_switch_seen = 0, man_move = 0, bad = 0;
  // leaving reset the contacts settle to off: one operation, no command behind it
  int mismatches = 0, checks_done = 0, stab = 0, cnt = 1, n;
  logic [31:0] xs = 32'd29;
  logic pos = 0, rem = 0, chg = 0, un = 1, iss, mv;
  logic [1:0] pins, c, ctl;
  logic [7:0] adr [6] = '{ADR_CTRL, ADR_CMD, ADR_PULSE, ADR_COUNT, ADR_IRQ_MASK, 8'h1c};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h3e8, 32'h1, 32'h0, 32'h0};
  always #12.5 core_clk = ~core_clk;

  breaker_state_and_command_gate #(.TICK_CYCLES(TK), .CNT_W(32)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .closed_status_in(closed_status_in),
    .open_status_in(open_status_in), .local_permit(local_permit),
    .remote_permit(remote_permit), .open_permit(open_permit), .close_permit(close_permit),
    .sync_check_ok(sync_check_ok), .operation_block(operation_block),
    .external_switch_seen(external_switch_seen), .open_cmd_pulse(open_cmd_pulse),
    .close_cmd_pulse(close_cmd_pulse), .operation_pulse(operation_pulse),
    .unintended_change(unintended_change), .breaker_state_code(breaker_state_code),
    .state_event(state_event), .irq(irq));

  breaker_model #(.TRAVEL(6)) i_brk (
    .core_clk(core_clk), .rst_n(rst_n), .open_cmd(open_cmd_pulse),
    .close_cmd(close_cmd_pulse), .man_move(man_move), .bad(bad),
    .closed_status_in(closed_status_in), .open_status_in(open_status_in));

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp_reg(q & m, e);
  endtask

  // ==========================================================
  // code and event monitor: compare the code only once pins settled through sync, the event every cycle
  always @(negedge core_clk) begin
    if (!rst_n) begin
      stab = 0;
      prev = STATE_MID;
      chg = 0;
    end else begin
      stab = ({closed_status_in, open_status_in} == pins) ? stab + 1 : 0;
      pins = {closed_status_in, open_status_in};
      if (stab > 3) cmp_reg(breaker_state_code, {30'h0, pins});
      cmp_bit(state_event, chg);
      chg = breaker_state_code !== prev;
      prev = breaker_state_code;
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial begin
    tick(3);
    rst_n <= 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) rd(adr[i], ALL, rv[i]);
    wb(1'b1, ADR_PULSE, 32'h2);
    wb(1'b1, ADR_IRQ_MASK, 32'h10);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      c = (r[11:10] == 2'h0) ? 2'h3 : r[11:10];
      ctl = {r[1] | r[18], r[0] | r[19]};
      local_permit <= r[2] | r[13];
      remote_permit <= r[3] | r[14];
      open_permit <= r[4] | r[15];
      close_permit <= r[5] | r[16];
      sync_check_ok <= r[6] | r[17];
      operation_block <= r[9:7] == 3'h0;
      wb(1'b1, ADR_CTRL, {30'h0, ctl});
      tick(3);
      iss = (c == 2'h1 ? open_permit : c == 2'h2 ? close_permit & sync_check_ok : 1'b0)
        & !operation_block & (r[12] ? ctl[1] & remote_permit : ctl[0] & local_permit);
      wb(1'b1, ADR_CMD, {29'h0, r[12], c});
      @(posedge core_clk);
      #1;
      cmp_bit(open_cmd_pulse, iss & c == 2'h1);
      cmp_bit(close_cmd_pulse, iss & c == 2'h2);
      // the sample just taken already counts the first pulse cycle
      n = 1;
      while ((open_cmd_pulse | close_cmd_pulse) && n < 99) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      if (iss) cmp_reg(n, 2 * TK);
      mv = iss & (c == 2'h1 ? pos : !pos);
      rem = rem | (iss & r[12]);
      tick(20);
      if (mv) begin
        pos = !pos;
        cnt++;
        un = !rem;
        rem = 0;
      end
      rd(ADR_STATUS, 32'h63, {25'h0, !iss, un, 3'h0, pos, !pos});
      rd(ADR_COUNT, ALL, cnt);
      cmp_bit(irq, iss);
      rd(ADR_IRQ_STAT, 32'h12, iss ? 32'h10 : 32'h2);
      wb(1'b1, ADR_IRQ_STAT, 32'h1f);
      tick(1);
      cmp_bit(irq, 1'b0);
    end
    // spontaneous moves, without and with an external switching hint
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 999 && operation_pulse === 1'b1; k++) @(posedge core_clk);
      external_switch_seen <= i[0];
      man_move <= 1'b1;
      @(posedge core_clk);
      man_move <= 1'b0;
      // hint only before the move, so it does not carry over to the next one
      external_switch_seen <= 1'b0;
      for (int k = 0; k < 99 && operation_pulse !== 1'b1; k++) @(posedge core_clk);
      n = 0;
      while (operation_pulse === 1'b1 && n < 999) begin
        @(posedge core_clk);
        n++;
      end
      cmp_reg(n, 150 * TK);
      pos = !pos;
      cnt++;
      un = !(rem | i[0]);
      rem = 0;
      cmp_bit(unintended_change, un);
      rd(ADR_COUNT, ALL, cnt);
    end
    // both contacts made is no operation; recovery is
    bad <= 1'b1;
    tick(10);
    rd(ADR_COUNT, ALL, cnt);
    bad <= 1'b0;
    tick(10);
    rd(ADR_STATUS, 32'h23, {26'h0, 1'b1, 3'h0, pos, !pos});
    rd(ADR_COUNT, ALL, cnt + 1);
    wb(1'b1, ADR_CTRL, 32'h7);
    tick(1);
    cmp_bit(operation_pulse, 1'b0);
    cmp_bit(unintended_change, 1'b0);
    rd(ADR_COUNT, ALL, 32'h0);
    rd(ADR_CTRL, ALL, 32'h3);
    // block raised while a command pulse runs cuts it short
    local_permit <= 1'b1;
    remote_permit <= 1'b1;
    open_permit <= 1'b1;
    close_permit <= 1'b1;
    sync_check_ok <= 1'b1;
    operation_block <= 1'b0;
    tick(3);
    wb(1'b1, ADR_CMD, pos ? 32'h5 : 32'h6);
    tick(2);
    operation_block <= 1'b1;
    tick(5);
    #1;
    cmp_bit(open_cmd_pulse | close_cmd_pulse, 1'b0);
    tick(30);
    rd(ADR_COUNT, ALL, 32'h1);
    cmp_bit(unintended_change, 1'b0);
    report_and_stop();
  end
endmodule // tb_breaker_state_and_command_gate
